// File: design/spc_port.sv
// How it works
// - every pin has its own weak pull-up, per-pin select bit
// - pull-up select bit one disables, zero enables
// - output direction forces the pull-up off
// - pull-ups disabled after reset, select register resets to all ones
// - pull-up also needs the global pull-up enable
// - per-pin change-interrupt enable, one enables
// - change-interrupt select resets to zero
// - enabled pins compared against level latched at last port read or write
// - mismatches ORed into port change flag, bit 0 of irq control
// - port change interrupt can wake the device from sleep
// - port read or write relatches compare values, except reg-to-reg move
// - flag sets on any enabled-pin change; irq output needs global and port change enables
// - pin three is I/O or active-low master clear input
// - pin three as output drives low only, open drain
// - pin two is I/O, timer clock input or edge interrupt
// - pin four is I/O, oscillator or instruction clock output
// - pin five is I/O, oscillator or external clock input
// - pins zero and one carry programming data and clock
// - TTL buffer, Schmitt trigger when used as edge interrupt
// - Schmitt trigger buffer while in programming mode
// - upper two bits of select registers read zero
// - direction one is input, zero drives the latch
// - all pins inputs after reset
// - latch register reads return the latch, not the pins
`timescale 1ns/1ns
`default_nettype none
module spc_port (
	input  wire logic        clk,
	input  wire logic        srst,
	// axi4-lite slave
	input  wire logic [13:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [13:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// core side
	input  wire logic        reg_to_reg_move,
	input  wire logic        prog_mode,
	input  wire logic        sleep_state,
	input  wire logic        instr_clock,
	input  wire logic        osc_out_drive,
	input  wire logic        osc_out_en,
	// pins
	input  wire logic [5:0]  pin_in,
	output logic [5:0]       pin_out,
	output logic [5:0]       pin_oe,
	output logic [5:0]       pullup_on,
	output logic [5:0]       schmitt_sel,
	output logic             port_change_irq,
	output logic             wake_request,
	output logic             timer_ext_clock_in,
	output logic             ext_edge_irq_in,
	output logic             master_clear_in_n,
	output logic             ext_clock_input,
	output logic             prog_data_in,
	output logic             prog_clock_in
);

	// ***************************************
	// registers and synchronisers
	// ***************************************
	logic [5:0] pullup_select;
	logic [5:0] change_irq_select;
	logic [5:0] direction_reg;
	logic [5:0] output_latch;
	logic [7:0] irq_control;
	logic [7:0] irq_control_two;
	logic [5:0] func_select;
	logic [5:0] sync_a;
	logic [5:0] pin_sync;
	logic [5:0] last_read;
	logic       port_touch;
	logic       flag_set;
	logic       flag_clear;
	logic       mismatch;

	// two stages; only pin_sync is read by logic
	always_ff @(posedge clk) begin
		sync_a   <= pin_in;
		pin_sync <= sync_a;
	end

	// ***************************************
	// axi4-lite write channel
	// ***************************************
	logic        aw_held;
	logic        w_held;
	logic [13:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;

	// address and data taken in either order, answer after both
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 14'h0000;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= spc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok(aw_addr) ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic addr_ok(input logic [13:0] a);
		case (a)
			spc_pkg::ADDR_CHANGE_IRQ_SELECT, spc_pkg::ADDR_PULLUP_SELECT,
			spc_pkg::ADDR_DIRECTION_REG, spc_pkg::ADDR_PORT_PINS,
			spc_pkg::ADDR_OUTPUT_LATCH, spc_pkg::ADDR_IRQ_CONTROL,
			spc_pkg::ADDR_IRQ_CONTROL_TWO, spc_pkg::ADDR_FUNC_SELECT,
			spc_pkg::ADDR_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	endfunction : addr_ok

	// byte lane 0 carries every register
	logic wr_lane;
	assign wr_lane = do_write && w_strb[0];

	// ***************************************
	// configuration registers
	// ***************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			pullup_select     <= spc_pkg::RST_PULLUP_SELECT;
			change_irq_select <= spc_pkg::RST_CHANGE_IRQ;
			direction_reg     <= spc_pkg::RST_DIRECTION;
			output_latch      <= spc_pkg::RST_OUTPUT_LATCH;
			irq_control_two   <= spc_pkg::RST_IRQ_CTRL_TWO;
			func_select       <= spc_pkg::RST_FUNC_SELECT;
		end else if (wr_lane) begin
			case (aw_addr)
				spc_pkg::ADDR_PULLUP_SELECT:     pullup_select     <= w_data[5:0];
				spc_pkg::ADDR_CHANGE_IRQ_SELECT: change_irq_select <= w_data[5:0];
				spc_pkg::ADDR_DIRECTION_REG:     direction_reg     <= w_data[5:0];
				// a port write lands in the latch, like the latch register
				spc_pkg::ADDR_PORT_PINS:         output_latch      <= w_data[5:0];
				spc_pkg::ADDR_OUTPUT_LATCH:      output_latch      <= w_data[5:0];
				spc_pkg::ADDR_IRQ_CONTROL_TWO:   irq_control_two   <= w_data[7:0];
				spc_pkg::ADDR_FUNC_SELECT:       func_select       <= w_data[5:0];
				default: ;
			endcase
		end
	end

	// ***************************************
	// axi4-lite read channel
	// ***************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= spc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= addr_ok(s_axi_araddr) ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				// upper bits read zero
				spc_pkg::ADDR_PULLUP_SELECT:     s_axi_rdata <= {26'h0, pullup_select};
				spc_pkg::ADDR_CHANGE_IRQ_SELECT: s_axi_rdata <= {26'h0, change_irq_select};
				spc_pkg::ADDR_DIRECTION_REG:     s_axi_rdata <= {26'h0, direction_reg};
				spc_pkg::ADDR_PORT_PINS:         s_axi_rdata <= {26'h0, pin_sync};
				spc_pkg::ADDR_OUTPUT_LATCH:      s_axi_rdata <= {26'h0, output_latch};
				spc_pkg::ADDR_IRQ_CONTROL:       s_axi_rdata <= {24'h0, irq_control};
				spc_pkg::ADDR_IRQ_CONTROL_TWO:   s_axi_rdata <= {24'h0, irq_control_two};
				spc_pkg::ADDR_FUNC_SELECT:       s_axi_rdata <= {26'h0, func_select};
				spc_pkg::ADDR_STATUS:            s_axi_rdata <= {26'h0, last_read};
				default:                         s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ***************************************
	// change detection
	// ***************************************
	// core moves flagged reg_to_reg_move leave the compare latch alone
	assign port_touch = !reg_to_reg_move &&
		((s_axi_arvalid && s_axi_arready && s_axi_araddr == spc_pkg::ADDR_PORT_PINS) ||
		 (do_write && aw_addr == spc_pkg::ADDR_PORT_PINS));

	always_ff @(posedge clk) begin
		if (srst) begin
			last_read <= 6'h00;
		end else if (port_touch) begin
			last_read <= pin_sync;
		end
	end

	assign mismatch   = |((pin_sync ^ last_read) & change_irq_select);
	assign flag_set   = mismatch;
	assign flag_clear = wr_lane && aw_addr == spc_pkg::ADDR_IRQ_CONTROL
		&& !w_data[spc_pkg::BIT_PORT_CHANGE_FLAG];

	// flag is sticky; a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_control <= spc_pkg::RST_IRQ_CONTROL;
		end else begin
			if (wr_lane && aw_addr == spc_pkg::ADDR_IRQ_CONTROL) begin
				irq_control[7:1] <= w_data[7:1];
			end
			if (flag_set) begin
				irq_control[spc_pkg::BIT_PORT_CHANGE_FLAG] <= 1'b1;
			end else if (flag_clear) begin
				irq_control[spc_pkg::BIT_PORT_CHANGE_FLAG] <= 1'b0;
			end
		end
	end

	// registered so the irq output comes from a flip-flop
	always_ff @(posedge clk) begin
		if (srst) begin
			port_change_irq <= 1'b0;
			wake_request    <= 1'b0;
		end else begin
			port_change_irq <= irq_control[spc_pkg::BIT_PORT_CHANGE_FLAG]
				&& irq_control[spc_pkg::BIT_PORT_CHANGE_IRQ_EN]
				&& irq_control[spc_pkg::BIT_GLOBAL_IRQ_EN];
			// wake needs only the local enable, the core decides on vectoring
			wake_request <= sleep_state && irq_control[spc_pkg::BIT_PORT_CHANGE_FLAG]
				&& irq_control[spc_pkg::BIT_PORT_CHANGE_IRQ_EN];
		end
	end

	// ***************************************
	// pin drivers and alternate functions
	// ***************************************
	logic [5:0] drive_oe;
	logic [5:0] drive_val;
	logic       global_pu;

	assign global_pu = !irq_control_two[spc_pkg::BIT_GLOBAL_PULLUP_EN]; // active low enable

	always_comb begin
		drive_oe  = ~direction_reg;
		drive_val = output_latch;
		// pin three as master clear is input only
		if (func_select[spc_pkg::BIT_FS_MASTER_CLEAR]) begin
			drive_oe[3] = 1'b0;
		end
		// open drain: enable only while pulling low
		drive_oe[3]  = drive_oe[3] && !output_latch[3];
		drive_val[3] = 1'b0;
		if (func_select[spc_pkg::BIT_FS_TIMER_CLK] || func_select[spc_pkg::BIT_FS_EDGE_IRQ]) begin
			drive_oe[2] = 1'b0;
		end
		if (func_select[spc_pkg::BIT_FS_OSC]) begin
			drive_oe[4]  = osc_out_en;
			drive_val[4] = osc_out_drive;
			drive_oe[5]  = 1'b0;
		end else if (func_select[spc_pkg::BIT_FS_INSTR_CLOCK_OUTPUT]) begin
			drive_oe[4]  = 1'b1;
			drive_val[4] = instr_clock;
		end
		if (func_select[spc_pkg::BIT_FS_EXT_CLK]) begin
			drive_oe[5] = 1'b0;
		end
		// programmer owns pins zero and one
		if (prog_mode) begin
			drive_oe[1:0] = 2'b00;
		end
	end

	assign pin_out = drive_val;
	assign pin_oe  = drive_oe;

	// pull-up: select low, global on, pin an input
	assign pullup_on = ~pullup_select & direction_reg & {6{global_pu}};

	always_comb begin
		schmitt_sel = 6'h00;
		if (func_select[spc_pkg::BIT_FS_EDGE_IRQ]) begin
			schmitt_sel[2] = 1'b1;
		end
		if (prog_mode) begin
			schmitt_sel = 6'h3F;
		end
	end

	// alternate inputs taken from the synchronised levels
	assign timer_ext_clock_in = func_select[spc_pkg::BIT_FS_TIMER_CLK] && pin_sync[2];
	assign ext_edge_irq_in    = func_select[spc_pkg::BIT_FS_EDGE_IRQ] && pin_sync[2];
	assign master_clear_in_n  = !func_select[spc_pkg::BIT_FS_MASTER_CLEAR] || pin_sync[3];
	assign ext_clock_input    = func_select[spc_pkg::BIT_FS_EXT_CLK] && pin_sync[5];
	assign prog_data_in       = prog_mode && pin_sync[0];
	assign prog_clock_in      = prog_mode && pin_sync[1];

	// ***************************************
	// assertions
	// ***************************************
	sequence change_seen_s;
		!srst && mismatch;
	endsequence

	flag_sticky_a: assert property (@(posedge clk) disable iff (srst)
		change_seen_s |=> irq_control[spc_pkg::BIT_PORT_CHANGE_FLAG])
		else $error("port change flag not set after mismatch");
	irq_gate_a: assert property (@(posedge clk) disable iff (srst)
		port_change_irq |-> $past(irq_control[spc_pkg::BIT_GLOBAL_IRQ_EN]))
		else $error("irq without global enable");
	pullup_output_a: assert property (@(posedge clk) disable iff (srst)
		(pullup_on & ~direction_reg) == 6'h00)
		else $error("pull-up on an output pin");
	pullup_global_a: assert property (@(posedge clk) disable iff (srst)
		irq_control_two[spc_pkg::BIT_GLOBAL_PULLUP_EN] |-> pullup_on == 6'h00)
		else $error("pull-up without global enable");
	reset_pullup_a: assert property (@(posedge clk)
		srst |=> pullup_select == 6'h3F && change_irq_select == 6'h00 && direction_reg == 6'h3F)
		else $error("wrong reset values");
	open_drain_a: assert property (@(posedge clk) disable iff (srst)
		pin_oe[3] |-> !pin_out[3])
		else $error("pin three driven high");
	relatch_a: assert property (@(posedge clk) disable iff (srst)
		port_touch |=> last_read == $past(pin_sync))
		else $error("compare latch not refreshed");
	input_hiz_a: assert property (@(posedge clk) disable iff (srst)
		(pin_oe & direction_reg) == 6'h00)
		else $error("input pin driven");
	// programming mode owns pins zero and one and all input buffers
	schmitt_prog_a: assert property (@(posedge clk) disable iff (srst)
		prog_mode |-> schmitt_sel == 6'h3F)
		else $error("programming mode without Schmitt inputs");
	prog_pins_a: assert property (@(posedge clk) disable iff (srst)
		prog_mode |-> pin_oe[1:0] == 2'b00)
		else $error("programming pins driven");
	// the wake request is registered, so sleep is seen one cycle earlier
	wake_sleep_a: assert property (@(posedge clk) disable iff (srst)
		wake_request |-> $past(sleep_state))
		else $error("wake request while awake");

endmodule : spc_port
`default_nettype wire

// File: design/spc_pkg.sv
package spc_pkg;
	// select registers sit at word indices; the byte address is four times the index
	localparam logic [11:0] IDX_CHANGE_IRQ_SELECT  = 12'hF78;
	localparam logic [11:0] IDX_PULLUP_SELECT      = 12'hF79;
	// byte addresses on the register bus
	localparam logic [13:0] ADDR_CHANGE_IRQ_SELECT = {IDX_CHANGE_IRQ_SELECT, 2'b00};
	localparam logic [13:0] ADDR_PULLUP_SELECT     = {IDX_PULLUP_SELECT, 2'b00};
	localparam logic [13:0] ADDR_DIRECTION_REG     = 14'h0F80;
	localparam logic [13:0] ADDR_PORT_PINS         = 14'h0F84;
	localparam logic [13:0] ADDR_OUTPUT_LATCH      = 14'h0F88;
	localparam logic [13:0] ADDR_IRQ_CONTROL       = 14'h0F8C;
	localparam logic [13:0] ADDR_IRQ_CONTROL_TWO   = 14'h0F90;
	localparam logic [13:0] ADDR_FUNC_SELECT       = 14'h0F94;
	localparam logic [13:0] ADDR_STATUS            = 14'h0F98;
	// reset values
	localparam logic [5:0] RST_PULLUP_SELECT = 6'h3F;
	localparam logic [5:0] RST_CHANGE_IRQ    = 6'h00;
	localparam logic [5:0] RST_DIRECTION     = 6'h3F;
	localparam logic [5:0] RST_OUTPUT_LATCH  = 6'h00;
	localparam logic [7:0] RST_IRQ_CONTROL   = 8'h00;
	localparam logic [7:0] RST_IRQ_CTRL_TWO  = 8'hE5;
	localparam logic [5:0] RST_FUNC_SELECT   = 6'h00;
	// field positions
	localparam int BIT_PORT_CHANGE_FLAG   = 0;
	localparam int BIT_PORT_CHANGE_IRQ_EN = 3;
	localparam int BIT_GLOBAL_IRQ_EN      = 7;
	localparam int BIT_PORT_CHANGE_PRIO   = 0;
	localparam int BIT_GLOBAL_PULLUP_EN   = 7;
	localparam int BIT_FS_TIMER_CLK       = 0;
	localparam int BIT_FS_EDGE_IRQ        = 1;
	localparam int BIT_FS_MASTER_CLEAR    = 2;
	localparam int BIT_FS_OSC             = 3;
	localparam int BIT_FS_INSTR_CLOCK_OUTPUT          = 4;
	localparam int BIT_FS_EXT_CLK         = 5;
	localparam int NUM_PINS = 6;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spc_pkg

// File: test/spc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module spc_pin_model (
	input  wire logic       clk,
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe,
	input  wire logic [5:0] pullup_on,
	input  wire logic [5:0] ext_en,
	input  wire logic [5:0] ext_val,
	output logic      [5:0] pin_level
);
	logic [5:0] flt = 6'h15;
	// an undriven pin wanders, so a stale level is never trusted
	always @(posedge clk) begin
		flt <= ~flt;
	end
	// device drive wins, then the board, then the weak pull-up
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (pin_oe[i]) pin_level[i] = pin_out[i];
			else if (ext_en[i]) pin_level[i] = ext_val[i];
			else if (pullup_on[i]) pin_level[i] = 1'b1;
			else pin_level[i] = flt[i];
		end
	end
endmodule : spc_pin_model
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk, srst, awv, wv, arv, bready, rready, move, prog, slp, iclk, od, oen;
	logic        awr, wr_rdy, bv, arr, rv, pci, wake, tck, eirq, mcn, eclk, pd, pc;
	logic [13:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [1:0]  br, rr, r;
	logic [5:0]  po, poe, pu, ss, lvl, ext_en, ext_val, v;
	logic [7:0]  d;
	int          num_errors, n_tests, seed;
	// ************************************************************
	// design and board
	// ************************************************************
	spc_port i_dut (.clk(clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .reg_to_reg_move(move),
		.prog_mode(prog), .sleep_state(slp), .instr_clock(iclk), .osc_out_drive(od),
		.osc_out_en(oen), .pin_in(lvl), .pin_out(po), .pin_oe(poe), .pullup_on(pu),
		.schmitt_sel(ss), .port_change_irq(pci), .wake_request(wake),
		.timer_ext_clock_in(tck), .ext_edge_irq_in(eirq), .master_clear_in_n(mcn),
		.ext_clock_input(eclk), .prog_data_in(pd), .prog_clock_in(pc));
	spc_pin_model i_pins (.clk(clk), .pin_out(po), .pin_oe(poe), .pullup_on(pu),
		.ext_en(ext_en), .ext_val(ext_val), .pin_level(lvl));
	// ************************************************************
	// bus and check tasks
	// ************************************************************
	// bready and rready stay high, so no task toggles them at a shared edge
	task automatic wr(input logic [13:0] a, input logic [7:0] x);
		logic aw_t, w_t;
		aw_t = 0;
		w_t = 0;
		awa <= a;
		wd <= {24'h0, x};
		awv <= 1;
		wv <= 1;
		do begin
			@(posedge clk);
			if (awr && !aw_t) begin
				aw_t = 1;
				awv <= 0;
			end
			if (wr_rdy && !w_t) begin
				w_t = 1;
				wv <= 0;
			end
		end while (!(aw_t && w_t));
		do @(posedge clk); while (bv !== 1'b1);
		r = br;
	endtask : wr
	task automatic rd(input logic [13:0] a);
		ara <= a;
		arv <= 1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 0;
		do @(posedge clk); while (rv !== 1'b1);
		d = rdat[7:0];
		r = rr;
	endtask : rd
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	// ************************************************************
	// clock, watchdog and scenarios
	// ************************************************************
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// a hang ends the run well past the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run;
	end
	initial begin
		{awv, wv, arv, move, prog, slp, iclk, od, oen} = 0;
		{bready, rready, srst} = 3'h7;
		{awa, ara, wd} = 0;
		ext_en = 6'h3F;
		ext_val = 6'h00;
		seed = 32'h592c9b52;
		repeat (20) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		chk("pullup_on", pu, 6'h00);
		chk("pin_oe", poe, 6'h00);
		chk("schmitt_sel", ss, 6'h00);
		rd(spc_pkg::ADDR_CHANGE_IRQ_SELECT);
		chk("change_irq_select", d, 8'h00);
		rd(spc_pkg::ADDR_PULLUP_SELECT);
		chk("pullup_select", d, 8'h3F);
		rd(spc_pkg::ADDR_DIRECTION_REG);
		chk("direction_reg", d, 8'h3F);
		rd(14'h0000);
		chk("unmapped resp", r, spc_pkg::RESP_SLVERR);
		wr(14'h0000, 8'hFF);
		chk("unmapped bresp", r, spc_pkg::RESP_SLVERR);
		wr(spc_pkg::ADDR_PULLUP_SELECT, 8'hFF);
		chk("bresp", r, spc_pkg::RESP_OKAY);
		rd(spc_pkg::ADDR_PULLUP_SELECT);
		chk("pullup_select", d, 8'h3F);
		wr(spc_pkg::ADDR_CHANGE_IRQ_SELECT, 8'hFF);
		rd(spc_pkg::ADDR_CHANGE_IRQ_SELECT);
		chk("change_irq_select", d, 8'h3F);
		// random pull-up, direction and global enable mixes
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			d = $random(seed);
			wr(spc_pkg::ADDR_PULLUP_SELECT, {2'h0, v});
			wr(spc_pkg::ADDR_DIRECTION_REG, {2'h0, d[5:0]});
			wr(spc_pkg::ADDR_IRQ_CONTROL_TWO, {d[7], 7'h65});
			chk("pullup_on", pu, ~v & d[5:0] & {6{~d[7]}});
		end
		// outputs: pin three only pulls low
		ext_en <= 6'h00;
		wr(spc_pkg::ADDR_DIRECTION_REG, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(spc_pkg::ADDR_OUTPUT_LATCH, {2'h0, v});
			chk("pin_oe", poe, {2'h3, ~v[3], 3'h7});
			chk("pin_out", po, v & 6'h37);
		end
		wr(spc_pkg::ADDR_DIRECTION_REG, 8'h3F);
		ext_en <= 6'h3F;
		ext_val <= ~v;
		repeat (4) @(posedge clk);
		rd(spc_pkg::ADDR_OUTPUT_LATCH);
		chk("output_latch", d, {2'h0, v});
		rd(spc_pkg::ADDR_PORT_PINS);
		chk("port_pins", d, {2'h0, ~v});
		// change detection on pins 0, 2 and 4
		wr(spc_pkg::ADDR_CHANGE_IRQ_SELECT, 8'h15);
		ext_val <= 6'h00;
		repeat (4) @(posedge clk);
		rd(spc_pkg::ADDR_PORT_PINS);
		wr(spc_pkg::ADDR_IRQ_CONTROL, 8'h88);
		ext_val <= 6'h02;
		repeat (6) @(posedge clk);
		chk("port_change_irq", pci, 1'b0);
		ext_val <= 6'h12;
		slp <= 1;
		repeat (6) @(posedge clk);
		chk("port_change_irq", pci, 1'b1);
		chk("wake_request", wake, 1'b1);
		wr(spc_pkg::ADDR_IRQ_CONTROL, 8'h88);
		rd(spc_pkg::ADDR_IRQ_CONTROL);
		chk("flag kept", d[0], 1'b1);
		move <= 1;
		rd(spc_pkg::ADDR_PORT_PINS);
		move <= 0;
		wr(spc_pkg::ADDR_IRQ_CONTROL, 8'h88);
		rd(spc_pkg::ADDR_IRQ_CONTROL);
		chk("flag after move", d[0], 1'b1);
		rd(spc_pkg::ADDR_PORT_PINS);
		chk("port_pins", d, 8'h12);
		wr(spc_pkg::ADDR_IRQ_CONTROL, 8'h88);
		rd(spc_pkg::ADDR_IRQ_CONTROL);
		chk("flag cleared", d[0], 1'b0);
		// a port write relatches as well; then mask globally
		ext_val <= 6'h01;
		repeat (6) @(posedge clk);
		wr(spc_pkg::ADDR_PORT_PINS, 8'h00);
		wr(spc_pkg::ADDR_IRQ_CONTROL, 8'h88);
		rd(spc_pkg::ADDR_IRQ_CONTROL);
		chk("flag after write", d[0], 1'b0);
		ext_val <= 6'h00;
		wr(spc_pkg::ADDR_IRQ_CONTROL, 8'h08);
		repeat (6) @(posedge clk);
		chk("masked irq", pci, 1'b0);
		// mid-run reset brings the select registers back
		srst <= 1;
		repeat (3) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		chk("pin_oe", poe, 6'h00);
		chk("port_change_irq", pci, 1'b0);
		rd(spc_pkg::ADDR_CHANGE_IRQ_SELECT);
		chk("change_irq_select", d, 8'h00);
		rd(spc_pkg::ADDR_PULLUP_SELECT);
		chk("pullup_select", d, 8'h3F);
		// alternate functions on pins 2, 3 and 5
		wr(spc_pkg::ADDR_FUNC_SELECT, 8'h27);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			ext_val <= v;
			repeat (4) @(posedge clk);
			chk("timer_ext_clock_in", tck, v[2]);
			chk("ext_edge_irq_in", eirq, v[2]);
			chk("master_clear_in_n", mcn, v[3]);
			chk("ext_clock_input", eclk, v[5]);
			chk("schmitt pin two", ss[2], 1'b1);
		end
		wr(spc_pkg::ADDR_DIRECTION_REG, 8'h2F);
		wr(spc_pkg::ADDR_FUNC_SELECT, 8'h10);
		iclk <= 1;
		@(posedge clk);
		chk("clock out", po[4], 1'b1);
		// oscillator: core drives pin four, pin five never driven
		wr(spc_pkg::ADDR_DIRECTION_REG, 8'h0F);
		wr(spc_pkg::ADDR_FUNC_SELECT, 8'h08);
		od <= 1;
		oen <= 1;
		@(posedge clk);
		chk("osc out", po[4], 1'b1);
		chk("osc pins oe", poe[5:4], 2'h1);
		prog <= 1;
		ext_val <= 6'h01;
		repeat (4) @(posedge clk);
		chk("schmitt_sel", ss, 6'h3F);
		chk("prog data", pd, 1'b1);
		chk("prog clock", pc, 1'b0);
		wr(spc_pkg::ADDR_DIRECTION_REG, 8'h00);
		chk("prog pins oe", poe[1:0], 2'h0);
		complete_run;
	end
endmodule : tb
`default_nettype wire
